/* File: hw/caf_defines.vh */
// constants for the can acceptance filter block
`ifndef CAF_DEFINES_VH
`define CAF_DEFINES_VH
`define CAF_ID_W 29
`define CAF_MSG_W 64
`define CAF_DLC_W 4
`define CAF_NFLT 16
`define CAF_NBUF 8
`define CAF_FIDX_W 4
`define CAF_BIDX_W 3
`define CAF_ADDR_W 6
// register word indices (byte address = 4 x index)
`define CAF_REG_CTRL 6'h00
`define CAF_REG_STATUS 6'h01
`define CAF_REG_MASK0 6'h02
`define CAF_REG_MASK1 6'h03
`define CAF_REG_HIT0 6'h04
`define CAF_REG_HIT1 6'h05
`define CAF_REG_LAST 6'h06
`define CAF_REG_ENABLE 6'h07
`define CAF_REG_FILT_BASE 6'h10
`define CAF_REG_ASSIGN_BASE 6'h20
// control fields
`define CAF_CTRL_ENH_BIT 0
`define CAF_CTRL_EXT_BIT 1
`define CAF_CTRL_RST 2'h0
`define CAF_ENABLE_RST 16'h003F
// mode encodings
`define CAF_MODE_BASIC 1'b0
`define CAF_MODE_ENH 1'b1
`endif

/* File: hw/caf_accept.v */
// acceptance filter, mask qualification and receive buffer loading
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// [RULE1] comparison starts only when a complete valid message sits in the message_assembly_buffer.
// [RULE2] a matching message is copied to the receive buffer tied to the matching filter, else none loads.
// [RULE3] an identifier bit whose mask bit is clear is always accepted.
// [RULE4] an identifier bit whose mask bit is set is accepted only if filter and identifier bits agree.
// [RULE5] in basic mode receive_buffer_zero is qualified by filters zero and one with mask zero.
// [RULE6] in basic mode receive_buffer_one is qualified by filters two to five with mask one.
// [RULE7] in enhanced mode sixteen filters each steer to any receive buffer chosen at run time.
// [RULE8] in enhanced mode a message matching several buffers loads only the lowest-numbered one.
// [RULE9] a filter matches only when every identifier bit is accepted.
`include "caf_defines.vh"
module caf_accept (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// message assembly buffer from the protocol engine
	input wire mab_valid_i,
	input wire [`CAF_ID_W-1:0] mab_id_i,
	input wire mab_ext_i,
	input wire [`CAF_DLC_W-1:0] mab_dlc_i,
	input wire [`CAF_MSG_W-1:0] mab_data_i,
	// register port
	input wire [`CAF_ADDR_W-1:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	// receive buffer load strobe and contents
	output reg rxb_load_o,
	output reg [`CAF_NBUF-1:0] rxb_sel_o,
	output reg [`CAF_ID_W-1:0] rxb_id_o,
	output reg rxb_ext_o,
	output reg [`CAF_DLC_W-1:0] rxb_dlc_o,
	output reg [`CAF_MSG_W-1:0] rxb_data_o,
	output reg [`CAF_FIDX_W-1:0] rxb_filter_o
);

	reg ctrl_enh_reg;
	reg ctrl_ext_reg;
	reg [`CAF_ID_W-1:0] mask0_reg;
	reg [`CAF_ID_W-1:0] mask1_reg;
	reg [`CAF_NFLT-1:0] enable_reg;
	reg [31:0] hit0_reg;
	reg [31:0] hit1_reg;
	reg [`CAF_NBUF-1:0] last_sel_reg;
	// filter contents live in the per-filter slices below, flattened for the muxes
	wire [`CAF_ID_W*`CAF_NFLT-1:0] filt_flat;
	wire [`CAF_BIDX_W*`CAF_NFLT-1:0] assign_flat;
	wire [`CAF_NFLT-1:0] filt_ext_vec;

	// per-filter storage, bit compare and match, one slice per filter entry
	wire [`CAF_NFLT-1:0] flt_hit;
	wire filt_wr;
	wire asgn_wr;
	wire [`CAF_NFLT-1:0] slot_hot;
	// filter values sit at 0x10+n, steering entries at 0x20+n
	assign filt_wr = reg_wr_i & (reg_addr_i[5:4] == 2'h1);
	assign asgn_wr = reg_wr_i & (reg_addr_i[5:4] == 2'h2);
	assign slot_hot = {{(`CAF_NFLT-1){1'b0}}, 1'b1} << reg_addr_i[`CAF_FIDX_W-1:0];
	genvar g;
	generate
		for (g = 0; g < `CAF_NFLT; g = g + 1) begin : g_flt
			reg [`CAF_ID_W-1:0] val_reg;
			reg ext_reg;
			reg [`CAF_BIDX_W-1:0] dest_reg;
			wire [`CAF_ID_W-1:0] msk;
			wire [`CAF_ID_W-1:0] bit_ok;
			always @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					val_reg <= {`CAF_ID_W{1'b0}};
					ext_reg <= 1'b0;
				end else if (filt_wr && slot_hot[g]) begin
					// bit 31 marks the filter as extended-frame
					val_reg <= reg_wdata_i[`CAF_ID_W-1:0];
					ext_reg <= reg_wdata_i[31];
				end
			end
			// steering is only looked at in enhanced mode
			always @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					dest_reg <= {`CAF_BIDX_W{1'b0}};
				end else if (asgn_wr && slot_hot[g]) begin
					dest_reg <= reg_wdata_i[`CAF_BIDX_W-1:0];
				end
			end
			assign filt_flat[g*`CAF_ID_W +: `CAF_ID_W] = val_reg;
			assign filt_ext_vec[g] = ext_reg;
			assign assign_flat[g*`CAF_BIDX_W +: `CAF_BIDX_W] = dest_reg;
			// filters 0,1 use mask zero, 2 to 5 mask one; filters 6 to 15 share mask zero/one by parity
			assign msk = (g < 2) ? mask0_reg : ((g < 6) ? mask1_reg :
				((g % 2 == 0) ? mask0_reg : mask1_reg));
			assign bit_ok = ~msk | ~(val_reg ^ mab_id_i); // RULE3 RULE4
			// a frame of the other format never matches, whatever the mask
			assign flt_hit[g] = (&bit_ok) & (ext_reg == mab_ext_i) & enable_reg[g]; // RULE9
		end
	endgenerate

	// fold filter hits onto buffers
	reg [`CAF_NBUF-1:0] buf_hit;
	reg [`CAF_FIDX_W-1:0] buf_flt [0:`CAF_NBUF-1];
	reg [`CAF_NBUF-1:0] sel_next;
	reg [`CAF_FIDX_W-1:0] flt_next;
	integer i;
	integer b;
	always @* begin
		buf_hit = {`CAF_NBUF{1'b0}};
		for (b = 0; b < `CAF_NBUF; b = b + 1) begin
			buf_flt[b] = {`CAF_FIDX_W{1'b0}};
		end
		if (ctrl_enh_reg == `CAF_MODE_BASIC) begin
			// basic mode: fixed association, only six filters take part
			for (i = 5; i >= 0; i = i - 1) begin
				if (flt_hit[i]) begin
					if (i < 2) begin
						buf_hit[0] = 1'b1; // RULE5
						buf_flt[0] = i[`CAF_FIDX_W-1:0];
					end else begin
						buf_hit[1] = 1'b1; // RULE6
						buf_flt[1] = i[`CAF_FIDX_W-1:0];
					end
				end
			end
		end else begin
			// descending scan so the lowest filter wins within one buffer
			for (i = `CAF_NFLT-1; i >= 0; i = i - 1) begin
				if (flt_hit[i]) begin
					buf_hit[assign_flat[i*`CAF_BIDX_W +: `CAF_BIDX_W]] = 1'b1; // RULE7
					buf_flt[assign_flat[i*`CAF_BIDX_W +: `CAF_BIDX_W]] = i[`CAF_FIDX_W-1:0];
				end
			end
		end
		// lowest-numbered buffer takes the message
		sel_next = {`CAF_NBUF{1'b0}};
		flt_next = {`CAF_FIDX_W{1'b0}};
		for (b = `CAF_NBUF-1; b >= 0; b = b - 1) begin
			if (buf_hit[b]) begin
				sel_next = {`CAF_NBUF{1'b0}};
				sel_next[b] = 1'b1; // RULE8
				flt_next = buf_flt[b];
			end
		end
	end

	// load strobe and one-hot select stand one cycle for each accepted valid cycle, so back-to-back accepted messages keep them high
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rxb_load_o <= 1'b0;
			rxb_sel_o <= {`CAF_NBUF{1'b0}};
		end else if (mab_valid_i && (|sel_next)) begin // RULE1
			rxb_load_o <= 1'b1; // RULE2
			rxb_sel_o <= sel_next;
		end else begin
			rxb_load_o <= 1'b0;
			rxb_sel_o <= {`CAF_NBUF{1'b0}};
		end
	end

	// message copy holds until the next accepted message
	// a rejected message leaves the last copy untouched, so software may still read it
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rxb_id_o <= {`CAF_ID_W{1'b0}};
			rxb_ext_o <= 1'b0;
			rxb_dlc_o <= {`CAF_DLC_W{1'b0}};
			rxb_data_o <= {`CAF_MSG_W{1'b0}};
			rxb_filter_o <= {`CAF_FIDX_W{1'b0}};
			last_sel_reg <= {`CAF_NBUF{1'b0}};
		end else if (mab_valid_i && (|sel_next)) begin // RULE2
			rxb_id_o <= mab_id_i;
			rxb_ext_o <= mab_ext_i;
			rxb_dlc_o <= mab_dlc_i;
			rxb_data_o <= mab_data_i;
			rxb_filter_o <= flt_next;
			last_sel_reg <= sel_next;
		end
	end

	// accepted and rejected message counts; they wrap silently
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hit0_reg <= 32'h0000_0000;
			hit1_reg <= 32'h0000_0000;
		end else if (mab_valid_i) begin
			if (|sel_next) begin
				hit0_reg <= hit0_reg + 32'h0000_0001;
			end else begin
				hit1_reg <= hit1_reg + 32'h0000_0001;
			end
		end
	end

	// control register; a mode change takes effect on the next message
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_enh_reg <= `CAF_MODE_BASIC;
			ctrl_ext_reg <= 1'b0;
		end else if (reg_wr_i && (reg_addr_i == `CAF_REG_CTRL)) begin
			ctrl_enh_reg <= reg_wdata_i[`CAF_CTRL_ENH_BIT];
			ctrl_ext_reg <= reg_wdata_i[`CAF_CTRL_EXT_BIT];
		end
	end

	// mask zero; reset clears it so every identifier bit is accepted
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask0_reg <= {`CAF_ID_W{1'b0}};
		end else if (reg_wr_i && (reg_addr_i == `CAF_REG_MASK0)) begin
			mask0_reg <= reg_wdata_i[`CAF_ID_W-1:0];
		end
	end

	// mask one
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask1_reg <= {`CAF_ID_W{1'b0}};
		end else if (reg_wr_i && (reg_addr_i == `CAF_REG_MASK1)) begin
			mask1_reg <= reg_wdata_i[`CAF_ID_W-1:0];
		end
	end

	// filter enables; only the six basic-mode filters are on after reset
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			enable_reg <= `CAF_ENABLE_RST;
		end else if (reg_wr_i && (reg_addr_i == `CAF_REG_ENABLE)) begin
			enable_reg <= reg_wdata_i[`CAF_NFLT-1:0];
		end
	end

	// read mux; unmapped reads give zero
	reg [31:0] rdata_next;
	always @* begin
		rdata_next = 32'h0000_0000;
		case (reg_addr_i)
			`CAF_REG_CTRL: rdata_next = {30'h0, ctrl_ext_reg, ctrl_enh_reg};
			`CAF_REG_STATUS: rdata_next = {24'h00_0000, last_sel_reg};
			`CAF_REG_MASK0: rdata_next = {3'h0, mask0_reg};
			`CAF_REG_MASK1: rdata_next = {3'h0, mask1_reg};
			`CAF_REG_HIT0: rdata_next = hit0_reg;
			`CAF_REG_HIT1: rdata_next = hit1_reg;
			`CAF_REG_LAST: rdata_next = {28'h000_0000, rxb_filter_o};
			`CAF_REG_ENABLE: rdata_next = {16'h0000, enable_reg};
			default: begin
				if (reg_addr_i[5:4] == 2'h1) begin
					rdata_next = {filt_ext_vec[reg_addr_i[3:0]], 2'h0,
						filt_flat[reg_addr_i[3:0]*`CAF_ID_W +: `CAF_ID_W]};
				end else if (reg_addr_i[5:4] == 2'h2) begin
					rdata_next = {29'h0,
						assign_flat[reg_addr_i[3:0]*`CAF_BIDX_W +: `CAF_BIDX_W]};
				end
			end
		endcase
	end

	// read data stands only in the cycle after the strobe, zero otherwise
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_next;
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

endmodule

/* File: verification/caf_chk.sv */
// port assertions for the acceptance filter
`timescale 1ns/100ps
module caf_chk (
	// clock, reset, register writes
	input wire clk_i,
	input wire rst_n_i,
	input wire [5:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	// message in, load out
	input wire mab_valid_i,
	input wire [28:0] mab_id_i,
	input wire mab_ext_i,
	input wire rxb_load_o,
	input wire [7:0] rxb_sel_o,
	input wire [28:0] rxb_id_o,
	input wire rxb_ext_o,
	input wire [3:0] rxb_filter_o
);
	reg enh_reg;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	always @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i) enh_reg <= 1'b0;
		else if (reg_wr_i && reg_addr_i == 6'h00) enh_reg <= reg_wdata_i[0];
	property p_src; rxb_load_o |-> $past(mab_valid_i); endproperty
	a_src: assert property (p_src) else $error("load without message");
	property p_id; rxb_load_o |-> rxb_id_o == $past(mab_id_i); endproperty
	a_id: assert property (p_id) else $error("identifier not copied");
	property p_ext; rxb_load_o |-> rxb_ext_o == $past(mab_ext_i); endproperty
	a_ext: assert property (p_ext) else $error("frame flag not copied");
	property p_quiet; !rxb_load_o |-> rxb_sel_o == 8'h00 && $stable(rxb_id_o); endproperty
	a_quiet: assert property (p_quiet) else $error("buffer touched without load");
	property p_one; rxb_load_o |-> $onehot(rxb_sel_o); endproperty
	a_one: assert property (p_one) else $error("not exactly one buffer");
	property p_b0; rxb_load_o && !enh_reg && rxb_sel_o[0] |-> rxb_filter_o < 4'h2; endproperty
	a_b0: assert property (p_b0) else $error("wrong filter for buffer zero");
	property p_b1; rxb_load_o && !enh_reg |-> rxb_sel_o[1] == (rxb_filter_o > 4'h1); endproperty
	a_b1: assert property (p_b1) else $error("wrong buffer in basic mode");
	property p_rng; rxb_load_o && !enh_reg |-> rxb_filter_o <= 4'h5; endproperty
	a_rng: assert property (p_rng) else $error("filter above five in basic mode");
endmodule
bind caf_accept caf_chk u_chk (.*);

/* File: verification/caf_mab_model.sv */
// stand-in protocol engine handing complete messages to the filter
`timescale 1ns/100ps
module caf_mab_model (
	// clock
	input wire clk_i,
	// message assembly buffer
	output reg mab_valid_o = 1'b0,
	output reg [28:0] mab_id_o = 29'h0,
	output reg mab_ext_o = 1'b0
);
	// valid stays high if send is called again at once
	task send(input [28:0] id, input ext);
		begin
			@(posedge clk_i);
			mab_valid_o <= 1'b1;
			mab_id_o <= id;
			mab_ext_o <= ext;
		end
	endtask
	// released fields show junk so a stale copy cannot pass
	task idle;
		begin
			@(posedge clk_i);
			mab_valid_o <= 1'b0;
			mab_id_o <= ~mab_id_o;
			mab_ext_o <= ~mab_ext_o;
		end
	endtask
endmodule

/* File: verification/test_can_acceptance_filter.sv */
// self-checking bench for the acceptance filter
`timescale 1ns/100ps
`include "caf_defines.vh"
module test_can_acceptance_filter;
	reg clk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg [5:0] reg_addr_i = 6'h00;
	reg [31:0] reg_wdata_i = 32'h0;
	reg reg_wr_i = 1'b0;
	reg reg_rd_i = 1'b0;
	wire mab_valid_i;
	wire [28:0] mab_id_i;
	wire mab_ext_i;
	wire [31:0] reg_rdata_o;
	wire rxb_load_o;
	wire [7:0] rxb_sel_o;
	wire [28:0] rxb_id_o;
	wire rxb_ext_o;
	wire [3:0] rxb_dlc_o;
	wire [63:0] rxb_data_o;
	wire [3:0] rxb_filter_o;
	integer n_fail = 0;
	integer total_checks = 0;
	caf_mab_model m (.clk_i(clk_i), .mab_valid_o(mab_valid_i), .mab_id_o(mab_id_i),
		.mab_ext_o(mab_ext_i));
	// payload and length follow the identifier so the copy is visible
	caf_accept dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .mab_valid_i(mab_valid_i),
		.mab_id_i(mab_id_i), .mab_ext_i(mab_ext_i), .mab_dlc_i(mab_id_i[3:0]),
		.mab_data_i({35'h0, mab_id_i}), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.rxb_load_o(rxb_load_o), .rxb_sel_o(rxb_sel_o), .rxb_id_o(rxb_id_o),
		.rxb_ext_o(rxb_ext_o), .rxb_dlc_o(rxb_dlc_o), .rxb_data_o(rxb_data_o),
		.rxb_filter_o(rxb_filter_o));
	initial forever #5 clk_i = ~clk_i;
	task finish_test;
		begin
			if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [5:0] a, input [31:0] d);
		begin
			@(posedge clk_i);
			reg_wr_i <= 1'b1;
			reg_addr_i <= a;
			reg_wdata_i <= d;
			@(posedge clk_i);
			reg_wr_i <= 1'b0;
		end
	endtask
	task rd(input [5:0] a, input [31:0] e);
		begin
			@(posedge clk_i);
			reg_rd_i <= 1'b1;
			reg_addr_i <= a;
			@(posedge clk_i);
			reg_rd_i <= 1'b0;
			#1;
			chk(reg_rdata_o, e);
		end
	endtask
	task msg(input [28:0] id, input ext, input [7:0] sel, input [3:0] f);
		begin
			m.send(id, ext);
			m.idle;
			#1;
			chk(rxb_sel_o, sel);
			chk(rxb_load_o, sel != 8'h00);
			if (sel != 8'h00) begin
				chk(rxb_filter_o, f);
				chk(rxb_id_o, id);
				chk({rxb_ext_o, rxb_dlc_o}, {ext, id[3:0]});
				chk(rxb_data_o[31:0], {3'h0, id});
				chk(rxb_data_o[63:32], 32'h0);
			end
		end
	endtask
	initial begin
		#20000;
		n_fail = n_fail + 1;
		finish_test;
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(`CAF_REG_MASK0, 32'h0);
		rd(`CAF_REG_ENABLE, 32'h3F);
		rd(6'h3F, 32'h0);
		msg(29'h1ABCDEF, 1'b0, 8'h01, 4'h0);
		msg(29'h1ABCDEF, 1'b1, 8'h00, 4'h0);
		wr(`CAF_REG_MASK0, 32'h1FFFFFFF);
		wr(`CAF_REG_FILT_BASE + 6'h01, 32'h123);
		msg(29'h123, 1'b0, 8'h01, 4'h1);
		msg(29'h122, 1'b0, 8'h02, 4'h2);
		wr(`CAF_REG_MASK1, 32'h1FFFFFFF);
		msg(29'h122, 1'b0, 8'h00, 4'h0);
		wr(`CAF_REG_FILT_BASE + 6'h05, 32'h1555);
		msg(29'h1555, 1'b0, 8'h02, 4'h5);
		wr(`CAF_REG_FILT_BASE + 6'h06, 32'h777);
		msg(29'h777, 1'b0, 8'h00, 4'h0);
		wr(`CAF_REG_CTRL, 32'h1);
		wr(`CAF_REG_ENABLE, 32'hFFFF);
		wr(`CAF_REG_ASSIGN_BASE + 6'h06, 32'h3);
		msg(29'h777, 1'b0, 8'h08, 4'h6);
		wr(`CAF_REG_FILT_BASE + 6'h0F, 32'h999);
		wr(`CAF_REG_ASSIGN_BASE + 6'h0F, 32'h7);
		msg(29'h999, 1'b0, 8'h80, 4'hF);
		wr(`CAF_REG_FILT_BASE + 6'h0E, 32'h999);
		wr(`CAF_REG_ASSIGN_BASE + 6'h0E, 32'h2);
		msg(29'h999, 1'b0, 8'h04, 4'hE);
		m.send(29'h123, 1'b0);
		msg(29'h1555, 1'b0, 8'h01, 4'h5);
		rd(`CAF_REG_HIT0, 32'h9);
		rd(`CAF_REG_HIT1, 32'h3);
		rd(`CAF_REG_STATUS, 32'h1);
		rd(`CAF_REG_LAST, 32'h5);
		rd(`CAF_REG_FILT_BASE + 6'h0F, 32'h999);
		rd(`CAF_REG_ASSIGN_BASE + 6'h0E, 32'h2);
		rd(`CAF_REG_CTRL, 32'h1);
		finish_test;
	end
endmodule
